// >>> pkg/eepec_params.svh
// Register offsets, field positions and reset values of the EEPROM control block
`ifndef EEPEC_PARAMS_SVH
`define EEPEC_PARAMS_SVH
`define EEPEC_OFS_MCR      8'hf0
`define EEPEC_OFS_PROT     8'hf1
`define EEPEC_OFS_TST      8'hf2
`define EEPEC_OFS_PROG     8'hf3
`define EEPEC_MCR_SWAI     7
`define EEPEC_MCR_LCK      3
`define EEPEC_MCR_RC       0
`define EEPEC_TST_ODD      7
`define EEPEC_TST_EVEN     6
`define EEPEC_TST_VOLTAGE_MARGIN_TEST     5
`define EEPEC_TST_CPD      4
`define EEPEC_TST_CPRD     3
`define EEPEC_TST_CPM      2
`define EEPEC_PG_BULK_ERASE_PROTECT     7
`define EEPEC_PG_BYTE      4
`define EEPEC_PG_ROW       3
`define EEPEC_PG_ERASE     2
`define EEPEC_PG_LAT       1
`define EEPEC_PG_PGM       0
`define EEPEC_RST_MCR      8'h80
`define EEPEC_RST_PROT     8'h1f
`define EEPEC_RST_TST      8'h00
`define EEPEC_RST_PROG     8'h80
`define EEPEC_ARR_BASE     12'hd00
`define EEPEC_ARR_WORDS    384
`define EEPEC_ROW_BYTES    32
`define EEPEC_ERASED       8'hff
`define EEPEC_RAMP_CYCLES  8'd16
`endif

// >>> pkg/eepec_pkg.sv
// Types of the EEPROM control block
package eepec_pkg;
   typedef enum logic [1:0] {
      EEPEC_IDLE = 2'b00,
      EEPEC_ARMED = 2'b01,
      EEPEC_HOLD = 2'b10,
      EEPEC_HV = 2'b11
   } eepec_state_t;
   typedef enum logic [1:0] {
      EEPEC_ER_BULK = 2'b00,
      EEPEC_ER_ROW = 2'b01,
      EEPEC_ER_LOC = 2'b10,
      EEPEC_ER_NONE = 2'b11
   } eepec_erase_t;
endpackage

// >>> design/eepec_top.sv
// EEPROM program/erase control with registers and array on Avalon-MM
`timescale 1ns/10ps
`include "eepec_params.svh"

module eepec_top #(
   parameter int NWORDS = `EEPEC_ARR_WORDS
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Avalon-MM slave, byte address
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [15:0] avs_writedata,
   input  wire logic [1:0]  avs_byteenable,
   output logic [15:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Device mode inputs
   input  wire logic        special_mode_n,
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   // Analog and clock controls
   output logic             module_clk_en,
   output logic             rc_osc_en,
   output logic             pump_on,
   output logic [7:0]       pump_level,
   output logic             margin_test,
   output logic             pump_monitor_out,
   output logic             hv_active
);
   logic [7:0]  mcr_r;
   logic [7:0]  prot_r;
   logic [7:0]  tst_r;
   logic [7:0]  prog_r;
   logic        lck_written_r;
   logic [15:0] mem_r [NWORDS];
   logic [11:0] lat_addr_r;
   logic [15:0] lat_data_r;
   logic [1:0]  lat_be_r;
   logic        lat_valid_r;
   logic        ack_r;
   logic [7:0]  ramp_r;
   eepec_pkg::eepec_state_t state_r;
   eepec_pkg::eepec_erase_t ersel;

   logic        acc;
   logic        is_reg;
   logic        is_arr;
   logic [7:0]  roff;
   logic [7:0]  wbyte;
   logic        pgm;
   logic        lat;
   logic        tmode;
   logic        hv;
   logic [8:0]  lat_word;
   logic [8:0]  acc_word;
   logic [4:0]  blk_hit;

   // Decode: registers in the low page, array 0x0d00-0x0fff
   assign acc    = (avs_read | avs_write) & ~ack_r;
   assign is_reg = (avs_address[11:2] == 10'h03c);
   assign is_arr = (avs_address >= `EEPEC_ARR_BASE);
   assign roff   = {6'h3c, avs_address[1:0]};
   assign wbyte  = avs_address[0] ? avs_writedata[15:8] : avs_writedata[7:0];
   assign pgm    = prog_r[`EEPEC_PG_PGM];
   assign lat    = prog_r[`EEPEC_PG_LAT];
   assign tmode  = tst_r[`EEPEC_TST_ODD] | tst_r[`EEPEC_TST_EVEN];
   assign acc_word = 9'((avs_address - `EEPEC_ARR_BASE) >> 1);
   assign lat_word = 9'((lat_addr_r - `EEPEC_ARR_BASE) >> 1);
   // High voltage only while enabled and not stopped
   assign hv     = pgm & lat_valid_r & ~stop_mode;

   // Block protect hit for the latched address
   assign blk_hit[4] = lat_addr_r[11:8] == 4'hd;
   assign blk_hit[3] = lat_addr_r[11:8] == 4'he;
   assign blk_hit[2] = lat_addr_r[11:7] == 5'h1e;
   assign blk_hit[1] = lat_addr_r[11:6] == 6'h3e;
   assign blk_hit[0] = lat_addr_r[11:6] == 6'h3f;

   // Erase size selection; none when erase-mode bit clear
   always_comb
   begin
      if (!prog_r[`EEPEC_PG_ERASE])
         ersel = eepec_pkg::EEPEC_ER_NONE;
      else if (prog_r[`EEPEC_PG_BYTE])
         ersel = eepec_pkg::EEPEC_ER_LOC;
      else if (prog_r[`EEPEC_PG_ROW])
         ersel = eepec_pkg::EEPEC_ER_ROW;
      else
         ersel = eepec_pkg::EEPEC_ER_BULK;
   end

   // Bus handshake: one wait cycle, then acknowledge
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ack_r <= 1'b0;
      else
         ack_r <= acc;
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~acc;
   end

   // Module configuration register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mcr_r         <= `EEPEC_RST_MCR;
         lck_written_r <= 1'b0;
      end
      else if (acc && avs_write && is_reg && roff == `EEPEC_OFS_MCR)
      begin
         mcr_r[`EEPEC_MCR_SWAI] <= wbyte[`EEPEC_MCR_SWAI];
         mcr_r[`EEPEC_MCR_RC]   <= wbyte[`EEPEC_MCR_RC];
         // Lock bit write once in normal modes
         if (!special_mode_n || !lck_written_r)
         begin
            mcr_r[`EEPEC_MCR_LCK] <= wbyte[`EEPEC_MCR_LCK];
            lck_written_r         <= 1'b1;
         end
      end
   end

   // Block protect register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prot_r <= `EEPEC_RST_PROT;
      // Write only with enable and lock clear
      else if (acc && avs_write && is_reg && roff == `EEPEC_OFS_PROT && !pgm && !mcr_r[`EEPEC_MCR_LCK])
         prot_r <= {3'h0, wbyte[4:0]};
   end

   // Test register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         tst_r <= `EEPEC_RST_TST;
      // Forced to zero in normal modes
      else if (special_mode_n)
         tst_r <= `EEPEC_RST_TST;
      else if (acc && avs_write && is_reg && roff == `EEPEC_OFS_TST)
         tst_r <= {wbyte[7:2], 2'b00};
   end

   // Program control register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         prog_r <= `EEPEC_RST_PROG;
      else if (acc && avs_write && is_reg && roff == `EEPEC_OFS_PROG)
      begin
         // Fields frozen while enabled; written in any combination
         if (!pgm)
         begin
            prog_r[`EEPEC_PG_BYTE]  <= wbyte[`EEPEC_PG_BYTE];
            prog_r[`EEPEC_PG_ROW]   <= wbyte[`EEPEC_PG_ROW];
            prog_r[`EEPEC_PG_ERASE] <= wbyte[`EEPEC_PG_ERASE];
            prog_r[`EEPEC_PG_LAT]   <= wbyte[`EEPEC_PG_LAT];
            // Bulk protect also needs lock clear
            if (!mcr_r[`EEPEC_MCR_LCK])
               prog_r[`EEPEC_PG_BULK_ERASE_PROTECT] <= wbyte[`EEPEC_PG_BULK_ERASE_PROTECT];
         end
         // Enable only once latch bit is already set
         prog_r[`EEPEC_PG_PGM] <= wbyte[`EEPEC_PG_PGM] & lat;
      end
   end

   // Address and data latches
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lat_addr_r  <= 12'h000;
         lat_data_r  <= 16'h0000;
         lat_be_r    <= 2'b00;
         lat_valid_r <= 1'b0;
      end
      else if (!lat)
         lat_valid_r <= 1'b0;
      else if (acc && avs_write && is_arr && !pgm)
      begin
         lat_addr_r  <= avs_address;
         lat_data_r  <= avs_writedata;
         lat_valid_r <= 1'b1;
         // Misaligned word keeps the upper byte only
         if (avs_address[0])
            lat_be_r <= 2'b10;
         else
            lat_be_r <= avs_byteenable;
      end
   end

   // Operation sequencer; held until software clears enable
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= eepec_pkg::EEPEC_IDLE;
      else
      begin
         case (state_r)
            eepec_pkg::EEPEC_IDLE:  state_r <= lat ? eepec_pkg::EEPEC_ARMED : eepec_pkg::EEPEC_IDLE;
            eepec_pkg::EEPEC_ARMED: state_r <= !lat ? eepec_pkg::EEPEC_IDLE
                                              : (hv ? eepec_pkg::EEPEC_HV : eepec_pkg::EEPEC_ARMED);
            // Stop mode parks the operation with enable kept
            eepec_pkg::EEPEC_HV:    state_r <= !pgm ? eepec_pkg::EEPEC_ARMED
                                              : (stop_mode ? eepec_pkg::EEPEC_HOLD : eepec_pkg::EEPEC_HV);
            eepec_pkg::EEPEC_HOLD:  state_r <= !pgm ? eepec_pkg::EEPEC_ARMED
                                              : (stop_mode ? eepec_pkg::EEPEC_HOLD : eepec_pkg::EEPEC_HV);
            default:                state_r <= eepec_pkg::EEPEC_IDLE;
         endcase
      end
   end

   // Charge pump ramp counter
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         ramp_r <= 8'h00;
      else if (state_r != eepec_pkg::EEPEC_HV || tst_r[`EEPEC_TST_CPD])
         ramp_r <= 8'h00;
      else if (tst_r[`EEPEC_TST_CPRD])
         ramp_r <= `EEPEC_RAMP_CYCLES;
      else if (ramp_r != `EEPEC_RAMP_CYCLES)
         ramp_r <= ramp_r + 8'h01;
   end

   // Array cells: program clears bits, erase sets them
   genvar gi;
   generate
      for (gi = 0; gi < NWORDS; gi++)
      begin : g_cell
         // Word index of this cell; a 32-byte row spans 16 words, so bit 4 is the row parity
         localparam logic [8:0] WIDX = 9'(gi);
         logic hit;
         logic row_odd;
         assign row_odd = WIDX[4];
         always_comb
         begin
            hit = 1'b0;
            if (state_r == eepec_pkg::EEPEC_HV && ramp_r == `EEPEC_RAMP_CYCLES)
            begin
               case (ersel)
                  // Bulk protect blocks bulk and row erase; alternate rows
                  eepec_pkg::EEPEC_ER_BULK:
                     hit = !prog_r[`EEPEC_PG_BULK_ERASE_PROTECT] && (tmode ? ((tst_r[`EEPEC_TST_ODD] && row_odd)
                           || (tst_r[`EEPEC_TST_EVEN] && !row_odd)) : 1'b1);
                  eepec_pkg::EEPEC_ER_ROW:
                     hit = !prog_r[`EEPEC_PG_BULK_ERASE_PROTECT] && (WIDX[8:4] == lat_word[8:4]);
                  default:
                     hit = (tmode && ersel == eepec_pkg::EEPEC_ER_NONE)
                           ? ((tst_r[`EEPEC_TST_ODD] && row_odd) || (tst_r[`EEPEC_TST_EVEN] && !row_odd))
                           : (WIDX == lat_word);
               endcase
            end
         end
         // Program and byte erase use the latched lanes; bulk, row and test-mode erase set the whole word
         always_ff @(posedge mclk)
         begin
            if (hit && !(|(blk_hit & prot_r[4:0])))
            begin
               if (ersel == eepec_pkg::EEPEC_ER_NONE)
                  mem_r[gi] <= mem_r[gi] & ~({{8{lat_be_r[1]}}, {8{lat_be_r[0]}}} & ~lat_data_r);
               else if (ersel != eepec_pkg::EEPEC_ER_LOC || tmode)
                  mem_r[gi] <= {`EEPEC_ERASED, `EEPEC_ERASED};
               else
                  mem_r[gi] <= mem_r[gi] | {{8{lat_be_r[1]}}, {8{lat_be_r[0]}}};
            end
         end
      end
   endgenerate

   // Read data path
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         avs_readdata <= 16'h0000;
      else if (acc && avs_read && is_reg)
      begin
         case (roff)
            `EEPEC_OFS_MCR:  avs_readdata <= {8'h00, mcr_r};
            `EEPEC_OFS_PROT: avs_readdata <= {8'h00, prot_r};
            `EEPEC_OFS_TST:  avs_readdata <= {8'h00, tst_r};
            `EEPEC_OFS_PROG: avs_readdata <= {8'h00, prog_r};
            default:         avs_readdata <= 16'h0000;
         endcase
      end
      // Array silent while latch bit set
      else if (acc && avs_read && is_arr && !lat)
         avs_readdata <= mem_r[acc_word];
      else if (acc && avs_read)
         avs_readdata <= 16'h0000;
   end

   // Analog and clock control outputs
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         module_clk_en    <= 1'b1;
         rc_osc_en        <= 1'b0;
         pump_on          <= 1'b0;
         pump_level       <= 8'h00;
         margin_test      <= 1'b0;
         pump_monitor_out <= 1'b0;
         hv_active        <= 1'b0;
      end
      else
      begin
         // Clock gated in wait mode when stop-in-wait set
         module_clk_en    <= ~(wait_mode & mcr_r[`EEPEC_MCR_SWAI]);
         // RC oscillator runs only when selected; stopped in stop mode
         rc_osc_en        <= mcr_r[`EEPEC_MCR_RC] & ~stop_mode;
         pump_on          <= (state_r == eepec_pkg::EEPEC_HV) & ~tst_r[`EEPEC_TST_CPD];
         pump_level       <= ramp_r;
         // Margin test and pump monitor routing
         margin_test      <= tst_r[`EEPEC_TST_VOLTAGE_MARGIN_TEST];
         pump_monitor_out <= tst_r[`EEPEC_TST_CPM];
         hv_active        <= state_r == eepec_pkg::EEPEC_HV;
      end
   end

   // Assertions
   a_lock_protect: assert property (@(posedge mclk) disable iff (!rst_n)
      (mcr_r[`EEPEC_MCR_LCK] || pgm) |=> $stable(prot_r))
      else $error("block protect changed while locked");
   a_pgm_needs_lat: assert property (@(posedge mclk) disable iff (!rst_n)
      $rose(pgm) |-> $past(lat))
      else $error("enable set without latch");
   a_test_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      special_mode_n |=> tst_r == 8'h00)
      else $error("test bits set in normal mode");
   a_fields_frozen: assert property (@(posedge mclk) disable iff (!rst_n)
      pgm |=> $stable(prog_r[7:1]))
      else $error("control fields changed while enabled");
   a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
      pgm && lat |=> $stable(lat_addr_r) && $stable(lat_data_r))
      else $error("latches changed while enabled");
   a_clk_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      wait_mode && mcr_r[`EEPEC_MCR_SWAI] |=> !module_clk_en)
      else $error("clock not gated in wait");
   a_stop_hv: assert property (@(posedge mclk) disable iff (!rst_n)
      stop_mode ##1 stop_mode |=> !pump_on && !rc_osc_en)
      else $error("pump or RC running in stop");
   a_pump_dis: assert property (@(posedge mclk) disable iff (!rst_n)
      tst_r[`EEPEC_TST_CPD] |=> !pump_on)
      else $error("pump on while disabled");
   a_lat_read: assert property (@(posedge mclk) disable iff (!rst_n)
      acc && avs_read && is_arr && lat |=> avs_readdata == 16'h0000)
      else $error("array data returned while latched");
   c_program: cover property (@(posedge mclk) disable iff (!rst_n) state_r == eepec_pkg::EEPEC_HV);
   c_stop_hold: cover property (@(posedge mclk) disable iff (!rst_n) state_r == eepec_pkg::EEPEC_HOLD);
   c_bulk: cover property (@(posedge mclk) disable iff (!rst_n) hit_any_bulk());
   function automatic logic hit_any_bulk();
      return (ersel == eepec_pkg::EEPEC_ER_BULK) && hv;
   endfunction
endmodule

// >>> tb/test_eeprom_program_erase_control.sv
// Self-checking testbench of the EEPROM program/erase control block
`timescale 1ns/10ps
`include "eepec_params.svh"
module test_eeprom_program_erase_control;
   // Clock and reset
   logic        mclk;
   logic        rst_n;
   // Avalon-MM master side
   logic [11:0] avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [15:0] avs_writedata;
   logic [1:0]  avs_byteenable;
   logic [15:0] avs_readdata;
   logic        avs_waitrequest;
   // Device modes and analog controls
   logic        special_mode_n;
   logic        wait_mode;
   logic        stop_mode;
   logic        module_clk_en;
   logic        rc_osc_en;
   logic        pump_on;
   logic [7:0]  pump_level;
   logic        margin_test;
   logic        pump_monitor_out;
   logic        hv_active;
   int          err_total;
   int          cmp_count;
   int          seed;
   int          cyc;
   int          idx;
   logic [15:0] q;
   logic [15:0] d;
   logic [15:0] e;
   logic [11:0] a;
   logic [4:0]  pr;
   logic        hit;

   eepec_top dut_u (
      .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .special_mode_n(special_mode_n),
      .wait_mode(wait_mode), .stop_mode(stop_mode), .module_clk_en(module_clk_en), .rc_osc_en(rc_osc_en),
      .pump_on(pump_on), .pump_level(pump_level), .margin_test(margin_test),
      .pump_monitor_out(pump_monitor_out), .hv_active(hv_active)
   );

   // Clock generation
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Hang guard
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total = err_total + 1;
         tally_and_finish();
      end
   end

   // Compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         err_total = err_total + 1;
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [11:0] ad, input logic [15:0] wd, input logic [1:0] be);
      @(posedge mclk);
      avs_address    <= ad;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      avs_write      <= w;
      avs_read       <= ~w;
      // Ends when waitrequest is sampled low; only the hang guard ends a wait that never sees it low
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      chk({15'h0000, avs_waitrequest}, 16'h0000);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Register byte write on its lane, and register or word read
   task automatic wr(input logic [11:0] ad, input logic [7:0] v);
      bus(1'b1, ad, ad[0] ? {v, 8'h00} : {8'h00, v}, ad[0] ? 2'b10 : 2'b01);
   endtask

   task automatic rd(input logic [11:0] ad);
      bus(1'b0, ad, 16'h0000, 2'b11);
   endtask

   // Which protect bit covers an array address
   function automatic logic prot_hit(input logic [11:0] ad, input logic [4:0] p);
      if (ad[11:8] == 4'hd)
         return p[4];
      if (ad[11:8] == 4'he)
         return p[3];
      if (ad[7] == 1'b0)
         return p[2];
      return ad[6] ? p[0] : p[1];
   endfunction

   // Full sequence: latch, array write, enable, hold, release
   task automatic prog_op(input logic [7:0] mode, input logic [11:0] ad, input logic [15:0] dat);
      wr(`EEPEC_OFS_PROG, mode | 8'h02);
      bus(1'b1, ad, dat, 2'b11);
      wr(`EEPEC_OFS_PROG, mode | 8'h03);
      repeat (20) @(posedge mclk);
      end_op();
   endtask

   // Close an operation: enable first, then latch, since fields freeze while enabled
   task automatic end_op();
      wr(`EEPEC_OFS_PROG, 8'h00);
      wr(`EEPEC_OFS_PROG, 8'h00);
      rd(`EEPEC_OFS_PROG); chk(q, 16'h0000);
   endtask

   // Main sequence
   initial
   begin
      err_total = 0; cmp_count = 0; cyc = 0; seed = 48;
      rst_n = 1'b0; avs_address = 12'h000; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 16'h0000; avs_byteenable = 2'b00;
      special_mode_n = 1'b1; wait_mode = 1'b0; stop_mode = 1'b0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      // Register reset values
      rd(`EEPEC_OFS_MCR);  chk(q, {8'h00, `EEPEC_RST_MCR});
      rd(`EEPEC_OFS_PROT); chk(q, {8'h00, `EEPEC_RST_PROT});
      rd(`EEPEC_OFS_TST);  chk(q, {8'h00, `EEPEC_RST_TST});
      rd(`EEPEC_OFS_PROG); chk(q, {8'h00, `EEPEC_RST_PROG});
      // Wait mode with stop-in-wait set gates the clock
      wait_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({15'h0000, module_clk_en}, 16'h0000);
      wait_mode <= 1'b0;
      // Lock accepts one write in normal mode, then freezes protect fields
      wr(`EEPEC_OFS_MCR, 8'h08);
      wr(`EEPEC_OFS_MCR, 8'h00);
      rd(`EEPEC_OFS_MCR); chk(q, 16'h0008);
      wait_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({15'h0000, module_clk_en}, 16'h0001);
      wait_mode <= 1'b0;
      wr(`EEPEC_OFS_PROT, 8'h00);
      rd(`EEPEC_OFS_PROT); chk(q, 16'h001f);
      wr(`EEPEC_OFS_PROG, 8'h00);
      rd(`EEPEC_OFS_PROG); chk(q, 16'h0080);
      // Special mode frees the lock; pump clock select and stop
      special_mode_n <= 1'b0;
      wr(`EEPEC_OFS_MCR, 8'h01);
      rd(`EEPEC_OFS_MCR); chk(q, 16'h0001);
      chk({15'h0000, rc_osc_en}, 16'h0001);
      stop_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({15'h0000, rc_osc_en}, 16'h0000);
      stop_mode <= 1'b0;
      // Test register in special mode, then forced to zero in normal mode
      d = $random(seed);
      wr(`EEPEC_OFS_TST, d[7:0]);
      rd(`EEPEC_OFS_TST); chk(q & 16'h00fc, {8'h00, d[7:0] & 8'hfc});
      chk({14'h0000, margin_test, pump_monitor_out}, {14'h0000, d[5], d[2]});
      special_mode_n <= 1'b1;
      wr(`EEPEC_OFS_TST, 8'hff);
      rd(`EEPEC_OFS_TST); chk(q, 16'h0000);
      // Clear protection; joint latch and enable write sets latch only
      wr(`EEPEC_OFS_PROT, 8'h00);
      rd(`EEPEC_OFS_PROT); chk(q, 16'h0000);
      wr(`EEPEC_OFS_PROG, 8'h03);
      rd(`EEPEC_OFS_PROG); chk(q, 16'h0002);
      wr(`EEPEC_OFS_PROG, 8'h00);
      // Random erase/program rounds, first one unprotected
      for (int i = 0; i < 5; i++)
      begin
         idx = $unsigned($random(seed)) % `EEPEC_ARR_WORDS;
         a = `EEPEC_ARR_BASE + 12'(idx * 2);
         wr(`EEPEC_OFS_PROT, 8'h00);
         prog_op(8'h14, a, 16'h0000);
         rd(a); chk(q, {`EEPEC_ERASED, `EEPEC_ERASED});
         pr = (i == 0) ? 5'h00 : 5'($random(seed));
         d = $random(seed);
         hit = prot_hit(a, pr);
         wr(`EEPEC_OFS_PROT, {3'b000, pr});
         wr(`EEPEC_OFS_PROG, 8'h02);
         bus(1'b1, a, d, 2'b11);
         rd(a); chk(q, 16'h0000);
         wr(`EEPEC_OFS_PROG, 8'h03);
         if (!hit)
         begin
            bus(1'b1, a, ~d, 2'b11);
            wr(`EEPEC_OFS_PROG, 8'h1d);
            rd(`EEPEC_OFS_PROG); chk(q, 16'h0003);
            chk({14'h0000, hv_active, pump_on}, 16'h0003);
         end
         repeat (20) @(posedge mclk);
         if (!hit)
            chk({8'h00, pump_level}, {8'h00, `EEPEC_RAMP_CYCLES});
         end_op();
         e = hit ? {`EEPEC_ERASED, `EEPEC_ERASED} : d;
         rd(a); chk(q, e);
      end
      // Bulk protect blocks a bulk erase
      wr(`EEPEC_OFS_PROT, 8'h00);
      prog_op(8'h84, a, 16'h0000);
      rd(a); chk(q, e);
      // Two programs without a read between, latch kept set
      wr(`EEPEC_OFS_PROG, 8'h02);
      d = $random(seed);
      e = e & d;
      bus(1'b1, a, d, 2'b11);
      wr(`EEPEC_OFS_PROG, 8'h03);
      repeat (20) @(posedge mclk);
      wr(`EEPEC_OFS_PROG, 8'h02);
      rd(`EEPEC_OFS_PROG); chk(q, 16'h0002);
      d = $random(seed);
      e = e & d;
      bus(1'b1, a, d, 2'b11);
      wr(`EEPEC_OFS_PROG, 8'h03);
      repeat (20) @(posedge mclk);
      end_op();
      rd(a); chk(q, e);
      // Row erase restores the latched row to the erased state
      prog_op(8'h0c, a, 16'h0000);
      rd(a); chk(q, {`EEPEC_ERASED, `EEPEC_ERASED});
      // Unmapped read returns zero
      rd(12'h100); chk(q, 16'h0000);
      tally_and_finish();
   end
endmodule
